// ### inc/rcs_pkg.sv
package rcs_pkg;
	// register byte addresses
	localparam logic [31:0] RCS_ADDR_CAUSE = 32'h01000008;
	localparam logic [31:0] RCS_ADDR_IRQ_STATUS = 32'h0100000C;
	localparam logic [31:0] RCS_ADDR_IRQ_MASK = 32'h01000010;
	localparam logic [31:0] RCS_ADDR_CONTROL = 32'h01000014;
	// field positions
	localparam int RCS_BIT_POWERON = 0;
	localparam int RCS_BIT_WATCHDOG = 1;
	localparam int RCS_BIT_PLL_ENABLE = 0;
	localparam int RCS_BIT_RESET_ACTIVE = 1;
	// values after reset
	localparam logic [1:0] RCS_CAUSE_RST = 2'h0;
	localparam logic [1:0] RCS_IRQ_STATUS_RST = 2'h0;
	localparam logic [1:0] RCS_IRQ_MASK_RST = 2'h0;
	localparam logic RCS_PLL_ENABLE_RST = 1'b0;
	// bus answers
	localparam logic [1:0] RCS_RESP_OKAY = 2'h0;
	localparam logic [1:0] RCS_RESP_SLVERR = 2'h2;
	// timing
	localparam int RCS_CLK_MHZ = 100;
	localparam int RCS_WDT_HOLD_MS = 10;
	localparam int RCS_WDT_HOLD_CYCLES = RCS_WDT_HOLD_MS * 1000 * RCS_CLK_MHZ;
	localparam int RCS_HOLD_CNT_W = 24;
	typedef enum logic [1:0] {
		RCS_SEL_CAUSE = 2'h0,
		RCS_SEL_IRQ_STATUS = 2'h1,
		RCS_SEL_IRQ_MASK = 2'h2,
		RCS_SEL_CONTROL = 2'h3
	} rcs_sel_t;
endpackage

// ### design/rcs_reset_unit.sv
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - watchdog reset sets the watchdog flag; it stays until cleared or another reset.
// - writing 0 clears the watchdog flag; writing 1 leaves it unchanged.
// - power-on reset pin sets the power-on flag; sticky like the watchdog flag.
// - writing 0 clears the power-on flag; writing 1 has no effect.
// - cause register bits 31:2 read zero and ignore writes.
// - internal reset asserts at once, unsynchronised, while the reset pin is low.
// - after either reset the PLL is off; everything runs from the oscillator.
// - reset returns pins to reset state; power-on also resets every module.
// - watchdog overflow asserts internal reset on the third aclk edge after it rises.
// - watchdog reset holds internal reset for about 10 ms.
// - the watchdog internal reset clears the watchdog reset request.
module rcs_reset_unit #(
	parameter int WDT_HOLD_CYCLES = rcs_pkg::RCS_WDT_HOLD_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic poweron_reset_n,
	input wire logic watchdog_overflow,
	output logic watchdog_clear,
	output logic sys_reset_n,
	output logic pin_reset_n,
	output logic module_reset_n,
	output logic pll_enable,
	output logic irq
);
	import rcs_pkg::*;

	// synchronisers; stage one feeds only stage two
	logic por_s1;
	logic por_s2;
	logic por_s3;
	logic wdt_s1;
	logic wdt_s2;
	logic wdt_s3;
	always_ff @(posedge aclk) begin
		por_s1 <= poweron_reset_n;
		por_s2 <= por_s1;
		por_s3 <= por_s2;
		wdt_s1 <= watchdog_overflow;
		wdt_s2 <= wdt_s1;
		wdt_s3 <= wdt_s2;
	end

	wire por_active = !por_s2;
	wire por_event = por_s3 && !por_s2;
	wire wdt_event = wdt_s2 && !wdt_s3 && !por_active;

	// watchdog hold counter; a new overflow edge reloads it, a pin reset cancels it
	// the hold counts aclk cycles, so its length tracks the clock rate
	localparam logic [RCS_HOLD_CNT_W-1:0] HOLD_LOAD = RCS_HOLD_CNT_W'(WDT_HOLD_CYCLES);
	logic [RCS_HOLD_CNT_W-1:0] hold_cnt;
	wire wdt_hold = hold_cnt != '0;
	logic [RCS_HOLD_CNT_W-1:0] next_hold_cnt;
	assign next_hold_cnt = por_active ? '0 :
		wdt_event ? HOLD_LOAD :
		wdt_hold ? hold_cnt - 1'b1 : hold_cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_cnt <= '0;
		end else begin
			hold_cnt <= next_hold_cnt;
		end
	end

	// raw pin gates the output so assertion needs no clock; release is registered
	wire sync_release = por_s2 && !wdt_hold;
	assign sys_reset_n = poweron_reset_n && sync_release;
	assign pin_reset_n = sys_reset_n;
	assign module_reset_n = poweron_reset_n && por_s2;
	assign watchdog_clear = wdt_hold;
	wire reset_active = !sync_release;

	// bus write path: address and data taken independently
	logic aw_held;
	logic w_held;
	logic [31:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire wr_fire = aw_held && w_held && !s_axi_bvalid;
	wire wsel_cause = awaddr_q == RCS_ADDR_CAUSE;
	wire wsel_status = awaddr_q == RCS_ADDR_IRQ_STATUS;
	wire wsel_mask = awaddr_q == RCS_ADDR_IRQ_MASK;
	wire wsel_ctrl = awaddr_q == RCS_ADDR_CONTROL;
	wire wsel_hit = wsel_cause || wsel_status || wsel_mask || wsel_ctrl;
	wire wr_low_byte = wr_fire && wstrb_q[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RCS_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				w_held <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wsel_hit ? RCS_RESP_OKAY : RCS_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// reset cause flags: a new cause clears the other flag, and beats a clear
	// loaded with RCS_CAUSE_RST by aresetn only, so the cause survives the internal reset
	logic pr_flag;
	logic wr_flag;
	wire clr_pr = wr_low_byte && wsel_cause && !wdata_q[RCS_BIT_POWERON];
	wire clr_wr = wr_low_byte && wsel_cause && !wdata_q[RCS_BIT_WATCHDOG];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{wr_flag, pr_flag} <= RCS_CAUSE_RST;
		end else if (por_active) begin
			pr_flag <= 1'b1;
			wr_flag <= 1'b0;
		end else if (wdt_event) begin
			wr_flag <= 1'b1;
			pr_flag <= 1'b0;
		end else begin
			if (clr_pr) begin
				pr_flag <= 1'b0;
			end
			if (clr_wr) begin
				wr_flag <= 1'b0;
			end
		end
	end

	// control: pll enable, forced off by any internal reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pll_enable <= RCS_PLL_ENABLE_RST;
		end else if (reset_active) begin
			pll_enable <= 1'b0;
		end else if (wr_low_byte && wsel_ctrl) begin
			pll_enable <= wdata_q[RCS_BIT_PLL_ENABLE];
		end
	end

	// read path
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	assign s_axi_arready = !s_axi_rvalid;
	wire rsel_cause = s_axi_araddr == RCS_ADDR_CAUSE;
	wire rsel_status = s_axi_araddr == RCS_ADDR_IRQ_STATUS;
	wire rsel_mask = s_axi_araddr == RCS_ADDR_IRQ_MASK;
	wire rsel_ctrl = s_axi_araddr == RCS_ADDR_CONTROL;
	wire rsel_hit = rsel_cause || rsel_status || rsel_mask || rsel_ctrl;
	wire [31:0] ctrl_word = {30'h0, reset_active, pll_enable};
	wire [31:0] read_word = rsel_cause ? {30'h0, wr_flag, pr_flag} :
		rsel_status ? {30'h0, irq_status} :
		rsel_mask ? {30'h0, irq_mask} :
		rsel_ctrl ? ctrl_word : 32'h00000000;
	wire status_rd_clr = ar_take && rsel_status;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RCS_RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= read_word;
			s_axi_rresp <= rsel_hit ? RCS_RESP_OKAY : RCS_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// interrupt: sticky events, read clears, a same-cycle event survives
	wire [1:0] irq_events = {wdt_event, por_event};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status <= RCS_IRQ_STATUS_RST;
			irq_mask <= RCS_IRQ_MASK_RST;
		end else begin
			irq_status <= (status_rd_clr ? 2'h0 : irq_status) | irq_events;
			if (wr_low_byte && wsel_mask) begin
				irq_mask <= wdata_q[1:0];
			end
		end
	end
	assign irq = |(irq_status & irq_mask);

	// checks
	localparam int WDT_SYNC_MAX = 4;
	logic rd_was_cause;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_was_cause <= 1'b0;
		end else if (ar_take) begin
			rd_was_cause <= rsel_cause;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence wdt_rise_s;
		$rose(wdt_s2) && por_s2 && !wdt_hold;
	endsequence
	sequence reset_seen_s;
		!sys_reset_n;
	endsequence

	wdt_flag_set_a: assert property (wdt_event |=> wr_flag && !pr_flag)
		else $error("watchdog flag not set on watchdog reset");
	wdt_flag_clear_a: assert property (clr_wr && !wdt_event && !por_active |=> !wr_flag)
		else $error("watchdog flag not cleared by zero write");
	wdt_flag_keep_a: assert property (wr_fire && wsel_cause && wdata_q[RCS_BIT_WATCHDOG]
		&& wr_flag && !por_active |=> wr_flag)
		else $error("writing one changed the watchdog flag");
	por_flag_set_a: assert property (por_active |=> pr_flag && !wr_flag)
		else $error("power-on flag not set");
	por_flag_clear_a: assert property (clr_pr && !wdt_event && !por_active |=> !pr_flag)
		else $error("power-on flag not cleared by zero write");
	cause_reserved_a: assert property (s_axi_rvalid && rd_was_cause
		|-> s_axi_rdata[31:2] == 30'h0)
		else $error("reserved cause bits not zero");
	por_immediate_a: assert property (!poweron_reset_n |-> reset_seen_s)
		else $error("internal reset not asserted with pin low");
	pll_off_a: assert property (reset_active |=> !pll_enable)
		else $error("pll left on during reset");
	wdt_latency_a: assert property ($rose(watchdog_overflow) && por_s2 && poweron_reset_n
		&& !wdt_hold |-> ##[1:WDT_SYNC_MAX] reset_seen_s)
		else $error("watchdog reset not asserted in time");
	hold_load_a: assert property (wdt_rise_s |=> hold_cnt == HOLD_LOAD)
		else $error("watchdog hold not loaded");
	hold_count_a: assert property (wdt_hold && !wdt_event && por_s2
		|=> hold_cnt == $past(hold_cnt) - 1'b1)
		else $error("watchdog hold did not count down");
	req_clear_a: assert property (wdt_hold |-> watchdog_clear && !sys_reset_n)
		else $error("watchdog request clear missing");
	sync_release_a: assert property ($rose(sys_reset_n) |-> $rose(sync_release) && por_s2
		&& !wdt_hold)
		else $error("reset released off the clock");

	// reset outputs, hold, bus answers and event bookkeeping
	module_reset_a: assert property (!poweron_reset_n |-> !module_reset_n && !pin_reset_n)
		else $error("pin or module reset missing with pin low");
	hold_cancel_a: assert property (por_active |=> !wdt_hold)
		else $error("power-on reset left the watchdog hold running");
	wdt_assert_a: assert property (wdt_event |=> !sys_reset_n)
		else $error("watchdog event did not assert reset");
	hold_release_a: assert property (hold_cnt == RCS_HOLD_CNT_W'(1) && por_s1 && por_s2
		&& !wdt_event |=> sync_release && !watchdog_clear)
		else $error("watchdog hold not released after its count");
	por_flag_keep_a: assert property (wr_fire && wsel_cause && wstrb_q[0] && pr_flag
		&& wdata_q[RCS_BIT_POWERON] && !wdt_event |=> pr_flag)
		else $error("writing one changed the power-on flag");
	status_event_a: assert property (wdt_event |=> irq_status[RCS_BIT_WATCHDOG])
		else $error("watchdog event not recorded");
	por_event_a: assert property (por_event |=> irq_status[RCS_BIT_POWERON])
		else $error("power-on event not recorded");
	status_clear_a: assert property (status_rd_clr && irq_events == 2'h0 |=> irq_status == 2'h0)
		else $error("status read did not clear");
	pll_write_a: assert property (wr_low_byte && wsel_ctrl && !reset_active
		|=> pll_enable == $past(wdata_q[RCS_BIT_PLL_ENABLE]))
		else $error("pll enable write lost");
	write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	write_error_a: assert property (wr_fire && !wsel_hit |=> s_axi_bresp == RCS_RESP_SLVERR)
		else $error("unmapped write not refused");
	read_error_a: assert property (ar_take && !rsel_hit
		|=> s_axi_rresp == RCS_RESP_SLVERR && s_axi_rdata == 32'h00000000)
		else $error("unmapped read not refused");
endmodule

// ### tb/rcs_partner.sv
`timescale 1ns/1ps
module rcs_partner (
	input wire logic aclk,
	input wire logic watchdog_clear,
	output logic poweron_reset_n,
	output logic watchdog_overflow
);
	// pin starts low: power is still settling at time zero
	initial begin
		poweron_reset_n = 1'b0;
		watchdog_overflow = 1'b0;
	end
	// request is withdrawn once the unit starts its hold
	always @(posedge aclk) if (watchdog_clear) watchdog_overflow <= 1'b0;
	task automatic pin_reset(input int n);
		poweron_reset_n <= 1'b0;
		repeat (n) @(posedge aclk);
		poweron_reset_n <= 1'b1;
	endtask
	task automatic fire;
		watchdog_overflow <= 1'b1;
	endtask
endmodule

// ### tb/reset_cause_and_sequencing_bench.sv
`timescale 1ns/1ps
module reset_cause_and_sequencing_bench;
	import rcs_pkg::*;
	localparam int HOLD = 20;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_rvalid, poweron_reset_n, watchdog_overflow, watchdog_clear;
	logic sys_reset_n, pin_reset_n, module_reset_n, pll_enable, irq;
	logic [31:0] d;
	int failures = 0;
	int cmp_count = 0;
	rcs_reset_unit #(.WDT_HOLD_CYCLES(HOLD)) i_dut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .poweron_reset_n, .watchdog_overflow, .watchdog_clear,
		.sys_reset_n, .pin_reset_n, .module_reset_n, .pll_enable, .irq);
	rcs_partner i_far (.aclk, .watchdog_clear, .poweron_reset_n, .watchdog_overflow);
	always #5 aclk = ~aclk;
	task automatic finish_test;
		if (failures == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic hang;
		failures++;
		finish_test();
	endtask
	// values read right after the edge are the ones that edge sampled
	task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		logic aw_done;
		logic w_done;
		logic b_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		b_done = 1'b0;
		rs = 2'h3;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50 && !b_done; n++) begin
			@(posedge aclk);
			if (s_axi_bvalid) begin
				b_done = 1'b1;
				rs = s_axi_bresp;
			end
			if (!aw_done && s_axi_awready) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b0;
		@(posedge aclk);
		if (!b_done) hang();
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		logic ar_done;
		logic r_done;
		ar_done = 1'b0;
		r_done = 1'b0;
		v = 32'hFFFFFFFF;
		rs = 2'h3;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50 && !r_done; n++) begin
			@(posedge aclk);
			if (s_axi_rvalid) begin
				r_done = 1'b1;
				v = s_axi_rdata;
				rs = s_axi_rresp;
			end
			if (!ar_done && s_axi_arready) begin
				ar_done = 1'b1;
				s_axi_arvalid <= 1'b0;
			end
		end
		s_axi_rready <= 1'b0;
		@(posedge aclk);
		if (!r_done) hang();
	endtask
	task automatic wait_rel;
		repeat (4) if (!sys_reset_n) @(negedge aclk);
		chk(sys_reset_n, 1, "release");
		@(posedge aclk);
	endtask
	task automatic t_poweron;
		i_far.pin_reset(3);
		wait_rel();
		rd(RCS_ADDR_CAUSE, d, r);
		chk(d, 32'h1, "cause after pin");
		wr(RCS_ADDR_CAUSE, 32'hFFFFFFFF, r);
		rd(RCS_ADDR_CAUSE, d, r);
		chk(d, 32'h1, "ones ignored");
		wr(RCS_ADDR_CAUSE, 32'h0, r);
		rd(RCS_ADDR_CAUSE, d, r);
		chk(d, 32'h0, "zero clears");
	endtask
	task automatic t_watchdog;
		int n;
		wr(RCS_ADDR_CONTROL, 32'h1, r);
		wr(RCS_ADDR_IRQ_MASK, 32'h2, r);
		chk(pll_enable, 1, "pll on");
		i_far.fire();
		repeat (4) if (sys_reset_n) @(negedge aclk);
		chk(sys_reset_n, 0, "wdt assert");
		chk(watchdog_clear, 1, "clear");
		n = 1;
		while (!sys_reset_n && n < 100) begin
			@(negedge aclk);
			if (!sys_reset_n) n++;
		end
		chk(n, HOLD, "hold length");
		chk(watchdog_overflow, 0, "request gone");
		chk(pll_enable, 0, "pll off");
		chk(irq, 1, "irq up");
		@(posedge aclk);
		rd(RCS_ADDR_CAUSE, d, r);
		chk(d, 32'h2, "cause wdt");
		rd(RCS_ADDR_IRQ_STATUS, d, r);
		chk(d, 32'h2, "irq status");
		chk(irq, 0, "read clears irq");
		wr(RCS_ADDR_CAUSE, 32'h2, r);
		rd(RCS_ADDR_CAUSE, d, r);
		chk(d, 32'h2, "one ignored");
		wr(RCS_ADDR_CAUSE, 32'h1, r);
		rd(RCS_ADDR_CAUSE, d, r);
		chk(d, 32'h0, "zero clears");
	endtask
	task automatic t_pin;
		fork
			i_far.pin_reset(5);
			begin
				#1;
				chk(sys_reset_n, 0, "pin assert");
				chk(module_reset_n, 0, "module reset");
				chk(pin_reset_n, 0, "pin state");
			end
		join
		wait_rel();
		chk(irq, 0, "masked event");
		rd(RCS_ADDR_IRQ_STATUS, d, r);
		chk(d, 32'h1, "pin event");
		rd(RCS_ADDR_CAUSE, d, r);
		chk(d, 32'h1, "cause pin");
	endtask
	task automatic t_unmapped;
		rd(32'h01000000, d, r);
		chk(r, RCS_RESP_SLVERR, "bad read");
		chk(d, 32'h0, "bad data");
		wr(32'h01000000, 32'h1, r);
		chk(r, RCS_RESP_SLVERR, "bad write");
	endtask
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_poweron();
		t_watchdog();
		t_pin();
		t_unmapped();
		finish_test();
	end
endmodule
